/* spoe_regs.svh */
// constants and contract of the serial-to-parallel output expander
// ****************************************************************
// Contract
// - The cascade output is always driven push-pull and ignores the output enable.
// - The device does no initialisation of its shift or storage stages on its own.
// - The storage register holds its value during shifting and changes only on a storage clock edge.
// - The active-low output enable high releases all parallel outputs without touching stored data.
// - Parallel outputs are open-drain: a stored low pulls low, a stored high is released.
// - Each rising shift clock edge with clear inactive loads serial data into stage one and shifts the rest.
// - A low shift clear forces all shift stages to zero but leaves the storage register alone.
// - Each rising storage clock edge copies all shift stages into the storage register.
// - On a shared edge the storage register takes the contents before the shift.
// ****************************************************************
`ifndef SPOE_REGS_SVH
`define SPOE_REGS_SVH
`define SPOE_WIDTH 8
`define SPOE_LAST_BIT 7
`define SPOE_RESET_BYTE 8'h00
`define SPOE_SYNC_STAGES 2
`endif

/* spoe_pkg.sv */
// types of the serial-to-parallel output expander
`include "spoe_regs.svh"
package spoe_pkg;
  typedef struct packed {
    logic chain_data_in;
    logic shift_clock;
    logic shift_clear_n;
    logic store_clock;
    logic out_enable_n;
  } spoe_pins_t;
endpackage : spoe_pkg

/* spoe_sync.sv */
// two-flop synchroniser for the controller pins
`timescale 1ns/1ps
module spoe_sync
  import spoe_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire spoe_pins_t pins_i,
  output spoe_pins_t pins_o
);
  spoe_pins_t meta_reg;
  spoe_pins_t meta_next;
  spoe_pins_t sync_reg;
  spoe_pins_t sync_next;

  always_comb begin
    meta_next = pins_i;
    sync_next = meta_reg;
    if (!rst_n_i) begin
      // clear inactive, enable released, clocks low
      meta_next = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      sync_next = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign pins_o = sync_reg;
endmodule : spoe_sync

/* spoe_expander.sv */
// serial-to-parallel output expander core
`timescale 1ns/1ps
`include "spoe_regs.svh"
module spoe_expander
  import spoe_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic chain_data_in_i,
  input wire logic shift_clock_i,
  input wire logic shift_clear_n_i,
  input wire logic store_clock_i,
  input wire logic out_enable_n_i,
  output logic [`SPOE_LAST_BIT:0] parallel_outputs_o,
  output logic [`SPOE_LAST_BIT:0] parallel_outputs_oe_n_o,
  output logic cascade_out_o
);
  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  spoe_pins_t pins_raw;
  spoe_pins_t pins_sync;

  assign pins_raw = '{chain_data_in_i, shift_clock_i, shift_clear_n_i, store_clock_i, out_enable_n_i};

  spoe_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(pins_raw),
    .pins_o(pins_sync)
  );

  // pins reach the logic two edges late
  a_sync_two_flops: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ($past(rst_n_i) && $past(rst_n_i, 2)) |-> pins_sync == $past(pins_raw, 2))
    else $error("pin synchroniser delay wrong");

  // ****************************************************************
  // edge detection
  // ****************************************************************
  logic shclk_prev_reg;
  logic shclk_prev_next;
  logic stclk_prev_reg;
  logic stclk_prev_next;
  logic shift_edge;
  logic store_edge;

  always_comb begin
    shclk_prev_next = rst_n_i ? pins_sync.shift_clock : 1'b0;
    stclk_prev_next = rst_n_i ? pins_sync.store_clock : 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    shclk_prev_reg <= shclk_prev_next;
    stclk_prev_reg <= stclk_prev_next;
  end

  assign shift_edge = pins_sync.shift_clock & ~shclk_prev_reg;
  assign store_edge = pins_sync.store_clock & ~stclk_prev_reg;

  // each pin edge acts exactly once
  a_shift_edge_once: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    shift_edge |=> !shift_edge)
    else $error("shift edge seen twice");
  a_store_edge_once: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    store_edge |=> !store_edge)
    else $error("storage edge seen twice");

  // ****************************************************************
  // shift and storage stages
  // ****************************************************************
  // stages power up unknown in the part; simulation reset to a fixed byte only
  logic [`SPOE_LAST_BIT:0] shift_reg;
  logic [`SPOE_LAST_BIT:0] shift_next;
  logic [`SPOE_LAST_BIT:0] store_reg;
  logic [`SPOE_LAST_BIT:0] store_next;
  logic cascade_reg;
  logic cascade_next;
  logic [`SPOE_LAST_BIT:0] pad_reg;
  logic [`SPOE_LAST_BIT:0] pad_next;
  logic [`SPOE_LAST_BIT:0] pad_oe_n_reg;
  logic [`SPOE_LAST_BIT:0] pad_oe_n_next;

  genvar gi;
  generate
    for (gi = 0; gi < `SPOE_WIDTH; gi = gi + 1) begin : g_stage
      always_comb begin
        // stage zero takes serial data, others the previous stage
        if (!pins_sync.shift_clear_n) begin
          shift_next[gi] = 1'b0;
        end else if (shift_edge) begin
          if (gi == 0) begin
            shift_next[gi] = pins_sync.chain_data_in;
          end else begin
            shift_next[gi] = shift_reg[(gi == 0) ? 0 : gi - 1];
          end
        end else begin
          shift_next[gi] = shift_reg[gi];
        end
        // storage copies the pre-shift value
        store_next[gi] = store_edge ? shift_reg[gi] : store_reg[gi];
        // open drain: drive low only for a stored low while enabled
        pad_next[gi] = 1'b0;
        pad_oe_n_next[gi] = pins_sync.out_enable_n | store_next[gi];
        // simulation reset only, the part powers up unknown
        if (!rst_n_i) begin
          shift_next[gi] = 1'b0;
          store_next[gi] = 1'b0;
          pad_oe_n_next[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // per stage: the first bit takes serial data, each other bit its neighbour on a shift edge
  genvar gk;
  generate
    for (gk = 0; gk < `SPOE_WIDTH; gk = gk + 1) begin : g_stage_check
      if (gk == 0) begin : g_first
        a_first_takes_data: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
          (shift_edge && pins_sync.shift_clear_n) |=> shift_reg[0] == $past(pins_sync.chain_data_in))
          else $error("first stage missed serial data");
      end else begin : g_rest
        a_stage_takes_prev: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
          (shift_edge && pins_sync.shift_clear_n) |=> shift_reg[gk] == $past(shift_reg[gk - 1]))
          else $error("stage missed previous stage");
      end
    end
  endgenerate

  always_comb begin
    cascade_next = shift_next[`SPOE_LAST_BIT];
  end

  always_ff @(posedge sys_clk_i) begin
    shift_reg <= shift_next;
    store_reg <= store_next;
    cascade_reg <= cascade_next;
    pad_reg <= pad_next;
    pad_oe_n_reg <= pad_oe_n_next;
  end

  assign parallel_outputs_o = pad_reg;
  assign parallel_outputs_oe_n_o = pad_oe_n_reg;
  assign cascade_out_o = cascade_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_clear_zeroes_stages: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !pins_sync.shift_clear_n |=> shift_reg == `SPOE_RESET_BYTE)
    else $error("shift stages not cleared");
  a_clear_keeps_store: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!pins_sync.shift_clear_n && !store_edge) |=> $stable(store_reg))
    else $error("clear disturbed storage");
  a_shift_moves_data: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (shift_edge && pins_sync.shift_clear_n) |=>
      shift_reg == {$past(shift_reg[`SPOE_LAST_BIT-1:0]), $past(pins_sync.chain_data_in)})
    else $error("shift stages did not advance");
  a_store_takes_old: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    store_edge |=> store_reg == $past(shift_reg))
    else $error("storage missed pre-shift contents");
  a_store_holds_value: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !store_edge |=> $stable(store_reg))
    else $error("storage changed without storage edge");
  a_cascade_tracks_last: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cascade_out_o == shift_reg[`SPOE_LAST_BIT])
    else $error("cascade out not last stage");
  a_disable_releases_all: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pins_sync.out_enable_n |=> parallel_outputs_oe_n_o == 8'hff)
    else $error("outputs driven while disabled");
  a_open_drain_level: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 (parallel_outputs_o == 8'h00) &&
      ($past(pins_sync.out_enable_n) || parallel_outputs_oe_n_o == store_reg))
    else $error("open-drain pad mismatch");
  a_shared_edge_lag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (shift_edge && store_edge && pins_sync.shift_clear_n) |=>
      store_reg[`SPOE_LAST_BIT-1:0] == shift_reg[`SPOE_LAST_BIT:1])
    else $error("shared edge did not lag");
  a_idle_shift_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!shift_edge && pins_sync.shift_clear_n) |=> $stable(shift_reg))
    else $error("shift stages moved without shift edge");
  a_clear_beats_shift: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!pins_sync.shift_clear_n && shift_edge) |=> shift_reg == `SPOE_RESET_BYTE)
    else $error("shift edge won over clear");
  a_clear_store_same: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!pins_sync.shift_clear_n && store_edge) |=> store_reg == $past(shift_reg))
    else $error("store during clear lost pre-clear contents");
  a_store_ignores_oe: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ($changed(pins_sync.out_enable_n) && !store_edge) |=> $stable(store_reg))
    else $error("output enable disturbed storage");

  // ****************************************************************
  // assertions: output pins
  // ****************************************************************
  a_oe_follows_store: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !pins_sync.out_enable_n |=> parallel_outputs_oe_n_o == store_reg)
    else $error("enabled pins differ from storage");
  a_store_reaches_pins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (store_edge && !pins_sync.out_enable_n) |=> parallel_outputs_oe_n_o == $past(shift_reg))
    else $error("stored byte did not reach pins");
  a_enable_restores: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(pins_sync.out_enable_n) |=> parallel_outputs_oe_n_o == store_reg)
    else $error("enable did not restore stored byte");
  a_pad_data_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    parallel_outputs_o == `SPOE_RESET_BYTE)
    else $error("open-drain pad data not low");
  a_cascade_ignores_oe: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ($changed(pins_sync.out_enable_n) && !shift_edge && pins_sync.shift_clear_n) |=> $stable(cascade_out_o))
    else $error("cascade out moved with output enable");
  a_cascade_next_bit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (shift_edge && pins_sync.shift_clear_n) |=> cascade_out_o == $past(shift_reg[`SPOE_LAST_BIT-1]))
    else $error("cascade out missed shifted bit");
  a_clear_cascade_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !pins_sync.shift_clear_n |=> !cascade_out_o)
    else $error("cascade out not low on clear");

  // ****************************************************************
  // assertions: simulation reset
  // ****************************************************************
  a_reset_outputs_idle: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> (parallel_outputs_oe_n_o == 8'hff && !cascade_out_o && store_reg == `SPOE_RESET_BYTE))
    else $error("reset did not idle the outputs");
endmodule : spoe_expander

/* spoe_ctrl_model.sv */
// controller pin model driving the expander pins
`timescale 1ns/1ps
module spoe_ctrl_model
  import spoe_pkg::*;
(
  input wire logic sys_clk_i,
  output spoe_pins_t pins_o
);
  initial pins_o = 5'b00100;
  // half a link clock period of 800 ns
  task automatic half;
    repeat (4) @(posedge sys_clk_i);
  endtask : half
  task automatic pulse(input logic sh, input logic st, input logic d);
    @(posedge sys_clk_i);
    pins_o.chain_data_in <= d;
    half();
    pins_o.shift_clock <= sh;
    pins_o.store_clock <= st;
    half();
    pins_o.shift_clock <= 1'b0;
    pins_o.store_clock <= 1'b0;
    pins_o.chain_data_in <= ~d;
    half();
  endtask : pulse
  // msb first, so a chained next stage fills in order
  task automatic shift_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) pulse(1'b1, 1'b0, d[i]);
  endtask : shift_byte
  task automatic clear;
    @(posedge sys_clk_i);
    pins_o.shift_clear_n <= 1'b0;
    half();
    pins_o.shift_clear_n <= 1'b1;
    half();
  endtask : clear
  task automatic set_oe(input logic v);
    @(posedge sys_clk_i);
    pins_o.out_enable_n <= v;
    half();
  endtask : set_oe
endmodule : spoe_ctrl_model

/* tb.sv */
// self-checking bench of the output expander
`timescale 1ns/1ps
module tb;
  import spoe_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  spoe_pins_t pins;
  logic [7:0] pads;
  logic [7:0] oe_n;
  logic casc;
  int err_count = 0;
  int samples_checked = 0;
  spoe_ctrl_model i_spoe_ctrl_model (.sys_clk_i(sys_clk_i), .pins_o(pins));
  spoe_expander i_spoe_expander (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .chain_data_in_i(pins.chain_data_in), .shift_clock_i(pins.shift_clock),
    .shift_clear_n_i(pins.shift_clear_n), .store_clock_i(pins.store_clock),
    .out_enable_n_i(pins.out_enable_n), .parallel_outputs_o(pads),
    .parallel_outputs_oe_n_o(oe_n), .cascade_out_o(casc));
  initial forever #50 sys_clk_i = ~sys_clk_i;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // ****************
  // scenarios
  // ****************
  task automatic t_load;
    i_spoe_ctrl_model.shift_byte(8'ha5);
    i_spoe_ctrl_model.pulse(1'b0, 1'b1, 1'b0);
    @(negedge sys_clk_i);
    check("oe_n", oe_n, 8'ha5);
    check("pads", pads, 8'h00);
    check("cascade", {7'h00, casc}, 8'h01);
  endtask : t_load
  task automatic t_hold_oe;
    i_spoe_ctrl_model.shift_byte(8'h3c);
    @(negedge sys_clk_i);
    check("held", oe_n, 8'ha5);
    i_spoe_ctrl_model.pulse(1'b0, 1'b1, 1'b1);
    i_spoe_ctrl_model.set_oe(1'b1);
    @(negedge sys_clk_i);
    check("oe off", oe_n, 8'hff);
    check("cascade oe", {7'h00, casc}, 8'h00);
    i_spoe_ctrl_model.set_oe(1'b0);
    @(negedge sys_clk_i);
    check("oe on", oe_n, 8'h3c);
  endtask : t_hold_oe
  task automatic t_shared;
    i_spoe_ctrl_model.shift_byte(8'h81);
    i_spoe_ctrl_model.pulse(1'b1, 1'b1, 1'b0);
    @(negedge sys_clk_i);
    check("pre shift", oe_n, 8'h81);
    check("cascade sh", {7'h00, casc}, 8'h00);
    i_spoe_ctrl_model.pulse(1'b0, 1'b1, 1'b1);
    @(negedge sys_clk_i);
    check("post shift", oe_n, 8'h02);
  endtask : t_shared
  task automatic t_clear;
    i_spoe_ctrl_model.shift_byte(8'hff);
    @(negedge sys_clk_i);
    check("cascade ff", {7'h00, casc}, 8'h01);
    i_spoe_ctrl_model.clear();
    @(negedge sys_clk_i);
    check("cascade clr", {7'h00, casc}, 8'h00);
    check("store kept", oe_n, 8'h02);
    i_spoe_ctrl_model.pulse(1'b0, 1'b1, 1'b1);
    @(negedge sys_clk_i);
    check("cleared out", oe_n, 8'h00);
  endtask : t_clear
  task automatic t_reset;
    i_spoe_ctrl_model.shift_byte(8'hc3);
    i_spoe_ctrl_model.pulse(1'b0, 1'b1, 1'b0);
    @(negedge sys_clk_i);
    check("stored c3", oe_n, 8'hc3);
    check("cascade c3", {7'h00, casc}, 8'h01);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check("reset oe_n", oe_n, 8'hff);
    check("reset cascade", {7'h00, casc}, 8'h00);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check("after reset", oe_n, 8'h00);
    i_spoe_ctrl_model.pulse(1'b1, 1'b0, 1'b1);
    i_spoe_ctrl_model.pulse(1'b0, 1'b1, 1'b0);
    @(negedge sys_clk_i);
    check("first after reset", oe_n, 8'h01);
  endtask : t_reset
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_load();
    t_hold_oe();
    t_shared();
    t_clear();
    t_reset();
    wrap_up();
  end
endmodule : tb
